/* logic/bmf_cfg.svh */
// constants for the bus matching fifo: offsets, pin positions, reset values
`ifndef BMF_CFG_SVH
`define BMF_CFG_SVH

`define BMF_DATA_W 36
`define BMF_ADDR_W 16
`define BMF_PIN_W 58
`define BMF_PIN_OE 0
`define BMF_PIN_RCLK 3
`define BMF_PIN_WCLK 8
`define BMF_LANE18_W 18
`define BMF_LANE9_W 9
`define BMF_OFS_SRC_W 32
`define BMF_RST_Q 36'h0_0000_0000

// default almost-flag offsets, indexed by {offset_access, sel1, sel0} at full reset
`define BMF_DEF_OFS0 16'h0007
`define BMF_DEF_OFS1 16'h001F
`define BMF_DEF_OFS2 16'h003F
`define BMF_DEF_OFS3 16'h007F
`define BMF_DEF_OFS4 16'h00FF
`define BMF_DEF_OFS5 16'h01FF
`define BMF_DEF_OFS6 16'h03FF
`define BMF_DEF_OFS7 16'h07FF

`endif

/* logic/bmf_pkg.sv */
// shared types of the bus matching fifo
package bmf_pkg;
  // port width codes, gray along 36 -> 18 -> 9
  typedef enum logic [1:0] {
    BMF_W36 = 2'h0,
    BMF_W18 = 2'h1,
    BMF_W9 = 2'h3
  } bmf_width_t;

  // which offset register the next parallel access touches
  typedef enum logic {
    BMF_OFS_EMPTY = 1'h0,
    BMF_OFS_FULL = 1'h1
  } bmf_ofs_sel_t;
endpackage

/* logic/bmf_pin_if.sv */
// pin bundle between the fifo core and its input synchroniser
`timescale 1ns/1ns
interface bmf_pin_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] lvl;
  logic [W-1:0] rise;
  modport sync_side (input raw, output lvl, output rise);
  modport user_side (output raw, input lvl, input rise);
endinterface

/* logic/bmf_pin_sync.sv */
// two-flop synchroniser with rising-edge detect for a bundle of pins
`timescale 1ns/1ns
module bmf_pin_sync
  import bmf_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // pins in, synchronised levels out
  bmf_pin_if.sync_side pins
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] lvl;
    logic [W-1:0] prev;
  } bmf_sync_t;

  bmf_sync_t sync_r;
  bmf_sync_t sync_nxt;

  // the meta stage feeds only the second stage
  always_comb begin
    sync_nxt.meta = pins.raw;
    sync_nxt.lvl = sync_r.meta;
    sync_nxt.prev = sync_r.lvl;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sync_r <= '0;
    end else begin
      sync_r <= sync_nxt;
    end
  end

  assign pins.lvl = sync_r.lvl;
  assign pins.rise = sync_r.lvl & ~sync_r.prev;
endmodule // bmf_pin_sync

/* logic/bmf_fifo.sv */
// bus matching fifo core: pin sampling, packing, memory, offsets and flags
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "bmf_cfg.svh"
module bmf_fifo
  import bmf_pkg::*;
#(
  parameter int AW = `BMF_ADDR_W
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // resets and configuration straps
  input wire logic full_reset_n_in,
  input wire logic partial_reset_n_in,
  input wire logic bus_match_sel_in,
  input wire logic input_width_sel_in,
  input wire logic output_width_sel_in,
  input wire logic byte_order_sel_in,
  input wire logic default_offset_sel0_in,
  input wire logic default_offset_sel1_in,
  input wire logic parity_placement_in,
  input wire logic prog_flag_timing_sel_in,
  input wire logic retransmit_latency_sel_in,
  input wire logic sync_write_sel_in,
  input wire logic sync_read_sel_in,
  // write side
  input wire logic write_clock_in,
  input wire logic write_enable_n_in,
  input wire logic [`BMF_DATA_W-1:0] data_in_in,
  input wire logic fall_through_sel_in,
  input wire logic serial_load_enable_n_in,
  input wire logic offset_access_n_in,
  // read side
  input wire logic read_clock_in,
  input wire logic read_enable_n_in,
  input wire logic replay_request_n_in,
  input wire logic output_drive_enable_n_in,
  // data and flags
  output logic [`BMF_DATA_W-1:0] data_out_out,
  output logic data_out_oe_out,
  output logic empty_flag_n_out,
  output logic full_flag_n_out,
  output logic half_full_flag_n_out,
  output logic almost_empty_flag_n_out,
  output logic almost_full_flag_n_out
);
  localparam logic [AW:0] DEPTH = (AW+1)'(1) << AW;
  localparam logic [AW:0] HALF = DEPTH >> 1;

  typedef struct packed {
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [1:0] wpart;
    logic [1:0] rpart;
    logic [`BMF_DATA_W-1:0] asm_word;
    logic [`BMF_DATA_W-1:0] rd_word;
    logic [`BMF_DATA_W-1:0] q;
    logic out_valid;
    logic replay_hold;
    bmf_ofs_sel_t ofs_wr_sel;
    bmf_ofs_sel_t ofs_rd_sel;
    logic [AW-1:0] ae_off;
    logic [AW-1:0] af_off;
    bmf_width_t in_w;
    bmf_width_t out_w;
    logic big_endian;
    logic fall_through_sel;
    logic serial_prog;
    logic interspersed;
    logic sync_pflag;
    logic zero_lat;
    logic sync_wr;
    logic sync_rd;
    logic ef_n;
    logic ff_n;
    logic hf_n;
    logic ae_n;
    logic af_n;
    logic oe;
  } bmf_state_t;

  localparam bmf_state_t ST_RST = '{in_w: BMF_W36, out_w: BMF_W36,
    ofs_wr_sel: BMF_OFS_EMPTY, ofs_rd_sel: BMF_OFS_EMPTY,
    ff_n: 1'b1, hf_n: 1'b1, af_n: 1'b1, default: '0};

  bmf_state_t state_r;
  bmf_state_t state_nxt;
  logic [`BMF_DATA_W-1:0] mem [0:(1<<AW)-1];

  // every pin passes two flops before the core looks at it
  bmf_pin_if #(.W(`BMF_PIN_W)) pin_bus ();
  assign pin_bus.raw = {data_in_in, full_reset_n_in, partial_reset_n_in, bus_match_sel_in,
    input_width_sel_in, output_width_sel_in, byte_order_sel_in, default_offset_sel0_in,
    default_offset_sel1_in, parity_placement_in, prog_flag_timing_sel_in,
    retransmit_latency_sel_in, sync_write_sel_in, sync_read_sel_in, write_clock_in,
    write_enable_n_in, fall_through_sel_in, serial_load_enable_n_in, offset_access_n_in,
    read_clock_in, read_enable_n_in, replay_request_n_in, output_drive_enable_n_in};

  bmf_pin_sync #(.W(`BMF_PIN_W)) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .pins(pin_bus.sync_side)
  );

  logic [`BMF_DATA_W-1:0] din;
  logic fr_n, pr_n, bm, iw, ow, be, fs0, fs1, ip, prog_flag_timing_sel, rm, asyw, asyr;
  logic wclk, wen_n, si, sen_n, ld_n, rclk, ren_n, rt_n, oe_n;
  assign {din, fr_n, pr_n, bm, iw, ow, be, fs0, fs1, ip, prog_flag_timing_sel, rm, asyw, asyr,
    wclk, wen_n, si, sen_n, ld_n, rclk, ren_n, rt_n, oe_n} = pin_bus.lvl;

  logic wclk_rise;
  logic rclk_rise;
  assign wclk_rise = pin_bus.rise[`BMF_PIN_WCLK];
  assign rclk_rise = pin_bus.rise[`BMF_PIN_RCLK];

  function automatic logic [1:0] last_part(input bmf_width_t wd);
    unique case (wd)
      BMF_W18: last_part = 2'h1;
      BMF_W9: last_part = 2'h3;
      default: last_part = 2'h0;
    endcase
  endfunction

  function automatic logic [1:0] slot_of(input logic [1:0] p, input bmf_width_t wd,
      input logic big);
    slot_of = big ? 2'(last_part(wd) - p) : p;
  endfunction

  function automatic logic [`BMF_DATA_W-1:0] put_part(input logic [`BMF_DATA_W-1:0] w,
      input logic [`BMF_DATA_W-1:0] d, input bmf_width_t wd, input logic [1:0] slot);
    logic [`BMF_DATA_W-1:0] r;
    r = w;
    unique case (wd)
      BMF_W18: r[slot[0]*`BMF_LANE18_W +: `BMF_LANE18_W] = d[`BMF_LANE18_W-1:0];
      BMF_W9: r[slot*`BMF_LANE9_W +: `BMF_LANE9_W] = d[`BMF_LANE9_W-1:0];
      default: r = d;
    endcase
    return r;
  endfunction

  // unused upper output lines read as zero
  function automatic logic [`BMF_DATA_W-1:0] get_part(input logic [`BMF_DATA_W-1:0] w,
      input bmf_width_t wd, input logic [1:0] slot);
    logic [`BMF_DATA_W-1:0] r;
    r = '0;
    unique case (wd)
      BMF_W18: r[`BMF_LANE18_W-1:0] = w[slot[0]*`BMF_LANE18_W +: `BMF_LANE18_W];
      BMF_W9: r[`BMF_LANE9_W-1:0] = w[slot*`BMF_LANE9_W +: `BMF_LANE9_W];
      default: r = w;
    endcase
    return r;
  endfunction

  function automatic logic [AW-1:0] def_ofs(input logic [2:0] sel);
    unique case (sel)
      3'h0: def_ofs = AW'(`BMF_DEF_OFS0);
      3'h1: def_ofs = AW'(`BMF_DEF_OFS1);
      3'h2: def_ofs = AW'(`BMF_DEF_OFS2);
      3'h3: def_ofs = AW'(`BMF_DEF_OFS3);
      3'h4: def_ofs = AW'(`BMF_DEF_OFS4);
      3'h5: def_ofs = AW'(`BMF_DEF_OFS5);
      3'h6: def_ofs = AW'(`BMF_DEF_OFS6);
      default: def_ofs = AW'(`BMF_DEF_OFS7);
    endcase
  endfunction

  logic [AW:0] count;
  logic [AW:0] free_cnt;
  logic full;
  logic avail;
  logic wr_hit;
  logic rd_hit;
  logic ofs_mode;
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [`BMF_DATA_W-1:0] mem_wdata;
  logic [`BMF_DATA_W-1:0] rd_mem;
  logic [`BMF_DATA_W-1:0] rd_first;
  logic [`BMF_OFS_SRC_W-1:0] ofs_src;

  // single clock: both pointers live in one domain, so the count is exact
  assign count = state_r.wr_ptr - state_r.rd_ptr;
  assign free_cnt = DEPTH - count;
  assign full = (count == DEPTH);
  assign avail = (count != '0) || (state_r.rpart != 2'h0);
  assign rd_mem = mem[state_r.rd_ptr[AW-1:0]];
  assign rd_first = mem[0];
  assign ofs_mode = ~ld_n;
  // asynchronous ports ignore the enables; the strobe edge alone acts
  assign wr_hit = wclk_rise & (~wen_n | ~state_r.sync_wr);
  assign rd_hit = rclk_rise & (~ren_n | ~state_r.sync_rd);

  always_comb begin
    logic [1:0] p;
    logic [`BMF_DATA_W-1:0] word;
    logic take;
    p = 2'h0;
    word = '0;
    take = 1'b0;
    state_nxt = state_r;
    mem_we = 1'b0;
    mem_waddr = state_r.wr_ptr[AW-1:0];
    mem_wdata = '0;
    ofs_src = state_r.interspersed ? {din[34:27], din[25:18], din[16:9], din[7:0]}
                                   : din[`BMF_OFS_SRC_W-1:0];
    if (!fr_n) begin
      // straps are caught only while full reset is held
      state_nxt = ST_RST;
      state_nxt.big_endian = ~be;
      state_nxt.fall_through_sel = si;
      state_nxt.serial_prog = ld_n;
      state_nxt.ae_off = def_ofs({ld_n, fs1, fs0});
      state_nxt.af_off = def_ofs({ld_n, fs1, fs0});
      state_nxt.interspersed = ip;
      state_nxt.sync_pflag = prog_flag_timing_sel;
      state_nxt.zero_lat = ~rm;
      state_nxt.sync_wr = asyw;
      state_nxt.sync_rd = asyr;
      if (!bm) begin
        state_nxt.in_w = BMF_W36;
        state_nxt.out_w = BMF_W36;
      end else begin
        state_nxt.in_w = !iw ? BMF_W36 : (ow ? BMF_W9 : BMF_W18);
        state_nxt.out_w = iw ? BMF_W36 : (ow ? BMF_W9 : BMF_W18);
      end
    end else if (!pr_n) begin
      // only data path state is cleared; modes and offsets stay
      state_nxt.wr_ptr = '0;
      state_nxt.rd_ptr = '0;
      state_nxt.wpart = 2'h0;
      state_nxt.rpart = 2'h0;
      state_nxt.q = `BMF_RST_Q;
      state_nxt.out_valid = 1'b0;
      state_nxt.replay_hold = 1'b0;
      state_nxt.ofs_wr_sel = BMF_OFS_EMPTY;
      state_nxt.ofs_rd_sel = BMF_OFS_EMPTY;
    end else begin
      // write side
      if (ofs_mode) begin
        if (state_r.serial_prog && wclk_rise && !sen_n) begin
          {state_nxt.af_off, state_nxt.ae_off} = {si, state_r.af_off, state_r.ae_off[AW-1:1]};
        end else if (!state_r.serial_prog && state_r.sync_wr && wclk_rise && !wen_n) begin
          unique case (state_r.ofs_wr_sel)
            BMF_OFS_EMPTY: begin
              state_nxt.ae_off = ofs_src[AW-1:0];
              state_nxt.ofs_wr_sel = BMF_OFS_FULL;
            end
            BMF_OFS_FULL: begin
              state_nxt.af_off = ofs_src[AW-1:0];
              state_nxt.ofs_wr_sel = BMF_OFS_EMPTY;
            end
          endcase
        end
      end else if (wr_hit && !full) begin
        state_nxt.asm_word = put_part(state_r.asm_word, din, state_r.in_w,
          slot_of(state_r.wpart, state_r.in_w, state_r.big_endian));
        if (state_r.wpart == last_part(state_r.in_w)) begin
          mem_we = 1'b1;
          mem_wdata = state_nxt.asm_word;
          state_nxt.wr_ptr = state_r.wr_ptr + 1'b1;
          state_nxt.wpart = 2'h0;
        end else begin
          state_nxt.wpart = state_r.wpart + 1'b1;
        end
      end
      // read side
      if (rclk_rise && !rt_n) begin
        // rewinds reads only; the writer keeps its place
        state_nxt.rd_ptr = '0;
        state_nxt.rpart = 2'h0;
        state_nxt.out_valid = 1'b0;
        state_nxt.replay_hold = 1'b1;
        if (state_r.zero_lat && state_r.wr_ptr != '0) begin
          state_nxt.rd_word = rd_first;
          state_nxt.rd_ptr = (AW+1)'(1);
          p = 2'h0;
          state_nxt.q = get_part(rd_first, state_r.out_w,
            slot_of(p, state_r.out_w, state_r.big_endian));
          state_nxt.rpart = (last_part(state_r.out_w) == 2'h0) ? 2'h0 : 2'h1;
          state_nxt.out_valid = 1'b1;
          state_nxt.replay_hold = 1'b0;
        end
      end else if (ofs_mode) begin
        if (state_r.sync_rd && rclk_rise && !ren_n) begin
          unique case (state_r.ofs_rd_sel)
            BMF_OFS_EMPTY: begin
              state_nxt.q = `BMF_DATA_W'(state_r.ae_off);
              state_nxt.ofs_rd_sel = BMF_OFS_FULL;
            end
            BMF_OFS_FULL: begin
              state_nxt.q = `BMF_DATA_W'(state_r.af_off);
              state_nxt.ofs_rd_sel = BMF_OFS_EMPTY;
            end
          endcase
        end
      end else begin
        if (rclk_rise) begin
          state_nxt.replay_hold = 1'b0;
        end
        // fall-through refills an idle output on any read clock edge
        if (state_r.fall_through_sel) begin
          take = rclk_rise && avail && !state_r.replay_hold && (!state_r.out_valid || rd_hit);
          if (rd_hit && !take) begin
            state_nxt.out_valid = 1'b0;
          end
        end else begin
          take = rd_hit && avail && !state_r.replay_hold;
        end
        if (take) begin
          if (state_r.rpart == 2'h0) begin
            word = rd_mem;
            state_nxt.rd_word = rd_mem;
            state_nxt.rd_ptr = state_r.rd_ptr + 1'b1;
          end else begin
            word = state_r.rd_word;
          end
          p = state_r.rpart;
          state_nxt.q = get_part(word, state_r.out_w,
            slot_of(p, state_r.out_w, state_r.big_endian));
          state_nxt.rpart = (p == last_part(state_r.out_w)) ? 2'h0 : 2'(p + 1'b1);
          state_nxt.out_valid = 1'b1;
        end
      end
    end
    // flags follow the registered counts one cycle later; with sync_pflag set the almost flags refresh only on strobe edges
    state_nxt.ef_n = state_r.fall_through_sel ? ~state_r.out_valid
                                  : (avail & ~state_r.replay_hold);
    state_nxt.ff_n = state_r.fall_through_sel ? full : ~full;
    state_nxt.hf_n = ~(count > HALF);
    if (!state_r.sync_pflag || rclk_rise) begin
      state_nxt.ae_n = (count >= {1'b0, state_r.ae_off});
    end
    if (!state_r.sync_pflag || wclk_rise) begin
      state_nxt.af_n = (free_cnt > {1'b0, state_r.af_off});
    end
    state_nxt.oe = ~oe_n;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= ST_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // storage carries no reset so it can map onto block memory
  always_ff @(posedge clk_sys_in) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  assign data_out_out = state_r.q;
  assign data_out_oe_out = state_r.oe;
  assign empty_flag_n_out = state_r.ef_n;
  assign full_flag_n_out = state_r.ff_n;
  assign half_full_flag_n_out = state_r.hf_n;
  assign almost_empty_flag_n_out = state_r.ae_n;
  assign almost_full_flag_n_out = state_r.af_n;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  a_full_reset_ptrs: assert property (!fr_n |=> state_r.wr_ptr == '0 && state_r.rd_ptr == '0
    && data_out_out == `BMF_RST_Q) else $error("full reset left pointers or output");
  a_partial_keeps_cfg: assert property (fr_n && !pr_n |=> $stable(state_r.ae_off)
    && $stable(state_r.fall_through_sel) && state_r.wr_ptr == '0) else $error("partial reset lost cfg");
  a_replay_rewind: assert property (fr_n && pr_n && rclk_rise && !rt_n
    |=> state_r.rd_ptr <= (AW+1)'(1)) else $error("replay did not rewind");
  a_std_full_flag: assert property (!state_r.fall_through_sel && full |=> !full_flag_n_out)
    else $error("full flag missing");
  a_std_empty_flag: assert property (!state_r.fall_through_sel && !avail |=> !empty_flag_n_out)
    else $error("empty flag missing");
  a_half_full_flag: assert property (count > HALF |=> !half_full_flag_n_out)
    else $error("half full flag wrong");
  a_almost_empty: assert property (!state_r.sync_pflag && count < {1'b0, state_r.ae_off}
    |=> !almost_empty_flag_n_out) else $error("almost empty flag wrong");
  a_almost_full: assert property (!state_r.sync_pflag && free_cnt > {1'b0, state_r.af_off}
    |=> almost_full_flag_n_out) else $error("almost full flag wrong");
  a_oe_follows_pin: assert property (!oe_n ##1 !oe_n |=> data_out_oe_out)
    else $error("output enable not followed");
  a_write_stores: assert property (fr_n && pr_n && !ofs_mode && wr_hit && !full
    && state_r.in_w == BMF_W36 |=> state_r.wr_ptr == $past(state_r.wr_ptr) + 1'b1)
    else $error("write not stored");

  c_fifo_full: cover property (full);
  c_replay_seen: cover property (rclk_rise && !rt_n && state_r.wr_ptr != '0);
  c_offset_load: cover property (ofs_mode && wclk_rise && !wen_n);
  c_fall_through_sel_first: cover property (state_r.fall_through_sel && !state_r.out_valid ##1 state_r.out_valid);
endmodule // bmf_fifo

/* bench/bmf_partner.sv */
// writer and reader model that works the fifo pins from outside
`timescale 1ns/1ns
module bmf_partner (
  // clock
  input wire logic clk_sys_in,
  // write side pins
  output logic write_clock_out,
  output logic write_enable_n_out,
  output logic [35:0] wr_data_out,
  // read side pins and completion pulse
  output logic read_clock_out,
  output logic read_enable_n_out,
  output logic replay_request_n_out,
  output logic rd_done_out
);
  initial begin
    write_clock_out = 1'h0;
    write_enable_n_out = 1'h1;
    wr_data_out = 36'h5_A5A5_A5A5;
    read_clock_out = 1'h0;
    read_enable_n_out = 1'h1;
    replay_request_n_out = 1'h1;
    rd_done_out = 1'h0;
  end

  // pins are synchronised inside, so each edge is held 4 cycles high and 5 low
  task automatic strobe(input bit rd, input bit rt, input logic [35:0] d);
    @(posedge clk_sys_in);
    if (rd) begin
      read_clock_out <= 1'h1;
      read_enable_n_out <= rt;
      replay_request_n_out <= ~rt;
    end else begin
      write_clock_out <= 1'h1;
      write_enable_n_out <= 1'h0;
      wr_data_out <= d;
    end
    repeat (4) @(posedge clk_sys_in);
    read_clock_out <= 1'h0;
    write_clock_out <= 1'h0;
    repeat (3) @(posedge clk_sys_in);
    read_enable_n_out <= 1'h1;
    replay_request_n_out <= 1'h1;
    write_enable_n_out <= 1'h1;
    // released data lines must not keep showing the old word
    wr_data_out <= ~wr_data_out;
    rd_done_out <= rd;
    @(posedge clk_sys_in);
    rd_done_out <= 1'h0;
  endtask
endmodule // bmf_partner

/* bench/tb_bus_matching_dual_clock_fifo.sv */
// self-checking bench: words through the fifo, flags, resets, replay, lane order
`timescale 1ns/1ns
`include "bmf_cfg.svh"
module tb_bus_matching_dual_clock_fifo;
  localparam int AW = 4;
  localparam int DEPTH = 16;
  localparam int OFS = 7;
  localparam int LIMIT = 6000;
  logic clk_sys_in = 1'h0;
  logic rst_in = 1'h1;
  logic full_reset_n = 1'h1, partial_reset_n = 1'h1, ofs_n = 1'h1, oe_n = 1'h0;
  logic bm = 1'h0, iw = 1'h0, ow = 1'h0, be = 1'h0, ft = 1'h0, rm = 1'h0;
  logic [1:0] dsel = 2'h0;
  logic wclk, wen_n, rclk, ren_n, rt_n, done, oe, ef_n, ff_n, hf_n, ae_n, af_n;
  logic [`BMF_DATA_W-1:0] din, dout;
  logic [31:0] seed = 32'h667D;
  logic [35:0] exp_q[$];
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int ae_ofs = OFS;
  int af_ofs = OFS;

  initial begin
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  bmf_partner i_far (.clk_sys_in(clk_sys_in), .write_clock_out(wclk),
    .write_enable_n_out(wen_n), .wr_data_out(din), .read_clock_out(rclk),
    .read_enable_n_out(ren_n), .replay_request_n_out(rt_n), .rd_done_out(done));

  bmf_fifo #(.AW(AW)) i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .full_reset_n_in(full_reset_n), .partial_reset_n_in(partial_reset_n),
    .bus_match_sel_in(bm), .input_width_sel_in(iw), .output_width_sel_in(ow),
    .byte_order_sel_in(be), .default_offset_sel0_in(dsel[0]),
    .default_offset_sel1_in(dsel[1]), .parity_placement_in(1'h0),
    .prog_flag_timing_sel_in(1'h0), .retransmit_latency_sel_in(rm),
    .sync_write_sel_in(1'h1), .sync_read_sel_in(1'h1), .write_clock_in(wclk),
    .write_enable_n_in(wen_n), .data_in_in(din), .fall_through_sel_in(ft),
    .serial_load_enable_n_in(1'h1), .offset_access_n_in(ofs_n),
    .read_clock_in(rclk), .read_enable_n_in(ren_n), .replay_request_n_in(rt_n),
    .output_drive_enable_n_in(oe_n), .data_out_out(dout), .data_out_oe_out(oe),
    .empty_flag_n_out(ef_n), .full_flag_n_out(ff_n), .half_full_flag_n_out(hf_n),
    .almost_empty_flag_n_out(ae_n), .almost_full_flag_n_out(af_n));

  function automatic logic [35:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return {seed[3:0], seed};
  endfunction

  task automatic cmp_val(input logic [35:0] exp, input logic [35:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // expected flags for k stored words against the offsets now in force
  task automatic chk_flags(input int k);
    cmp_val({k != 0, k != DEPTH, k <= DEPTH / 2, k >= ae_ofs, DEPTH - k > af_ofs},
      {ef_n, ff_n, hf_n, ae_n, af_n});
  endtask

  task automatic wr(input logic [35:0] d);
    i_far.strobe(1'b0, 1'b0, d);
  endtask

  task automatic rd(input logic [35:0] e, input bit rt);
    exp_q.push_back(e);
    i_far.strobe(1'b1, rt, 36'h0);
  endtask

  // offset access held low through full reset picks parallel loading
  task automatic pulse_reset(input bit full);
    @(posedge clk_sys_in);
    full_reset_n <= ~full;
    partial_reset_n <= full;
    ofs_n <= ~full;
    if (full) begin
      ae_ofs = OFS;
      af_ofs = OFS;
    end
    repeat (5) @(posedge clk_sys_in);
    full_reset_n <= 1'h1;
    partial_reset_n <= 1'h1;
    @(posedge clk_sys_in);
    ofs_n <= 1'h1;
    repeat (4) @(posedge clk_sys_in);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge done) begin
    if (exp_q.size() == 0) begin
      cmp_val(36'h0, 36'hF_FFFF_FFFF);
    end else begin
      cmp_val(exp_q.pop_front(), dout);
    end
  end

  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    logic [35:0] w;
    logic [35:0] part;
    logic [35:0] mq[$];
    int pw;
    int sh;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'h0;
    pulse_reset(1'b1);
    chk_flags(0);
    cmp_val(36'h0, dout);
    cmp_val(36'h1, {35'h0, oe});
    oe_n <= 1'h1;
    repeat (5) @(posedge clk_sys_in);
    cmp_val(36'h0, {35'h0, oe});
    oe_n <= 1'h0;
    // one write past full must be dropped
    for (int k = 1; k <= DEPTH + 1; k++) begin
      w = rnd();
      if (k <= DEPTH) mq.push_back(w);
      wr(w);
      chk_flags(k > DEPTH ? DEPTH : k);
    end
    for (int k = DEPTH - 1; k >= 0; k--) begin
      rd(mq.pop_front(), 1'b0);
      chk_flags(k);
    end
    // parallel offset load and read-back; the partial reset must keep them
    ofs_n <= 1'h0;
    wr(36'h3);
    wr(36'hC);
    rd(36'h3, 1'b0);
    rd(36'hC, 1'b0);
    ofs_n <= 1'h1;
    ae_ofs = 3;
    af_ofs = 12;
    for (int k = 0; k < 3; k++) wr(rnd());
    pulse_reset(1'b0);
    chk_flags(0);
    cmp_val(36'h0, dout);
    for (int k = 0; k < OFS; k++) begin
      w = rnd();
      mq.push_back(w);
      wr(w);
    end
    chk_flags(OFS);
    rd(mq[0], 1'b0);
    rd(mq[1], 1'b0);
    rd(mq[0], 1'b1);
    rd(mq[1], 1'b0);
    // normal latency replay: the first read edge only lifts the forced empty
    rm <= 1'h1;
    pulse_reset(1'b1);
    w = rnd();
    part = rnd();
    wr(w);
    wr(part);
    rd(w, 1'b0);
    rd(part, 1'b0);
    rd(part, 1'b1);
    cmp_val(36'h0, {35'h0, ef_n});
    rd(part, 1'b0);
    rd(w, 1'b0);
    // fall-through: the first read edge brings the head word out
    rm <= 1'h0;
    ft <= 1'h1;
    pulse_reset(1'b1);
    cmp_val(36'h2, {34'h0, ef_n, ff_n});
    w = rnd();
    part = rnd();
    wr(w);
    wr(part);
    rd(w, 1'b0);
    rd(part, 1'b0);
    rd(part, 1'b0);
    cmp_val(36'h1, {35'h0, ef_n});
    ft <= 1'h0;
    // every narrow width and both byte orders on each side
    for (int c = 0; c < 8; c++) begin
      @(posedge clk_sys_in);
      bm <= 1'h1;
      be <= c[0];
      iw <= c[1];
      ow <= c[2];
      pulse_reset(1'b1);
      w = rnd();
      pw = c[2] ? 9 : 18;
      for (int j = 0; j < 36 / pw; j++) begin
        sh = c[0] ? pw * j : 36 - pw * (j + 1);
        part = (w >> sh) & ~(36'hF_FFFF_FFFF << pw);
        if (c[1]) wr(part | (rnd() << pw));
        else if (j == 0) wr(w);
        if (!c[1]) rd(part, 1'b0);
      end
      if (c[1]) rd(w, 1'b0);
    end
    repeat (3) @(posedge clk_sys_in);
    wrap_up();
  end
endmodule // tb_bus_matching_dual_clock_fifo
